// ===== verilog/coproc_decode_pkg.sv
// coprocessor instruction decode constants
// assumes a 32-bit instruction word and a 20 MHz core clock
package coproc_decode_pkg;
  localparam int COND_MSB     = 31;
  localparam int COND_LSB     = 28;
  localparam logic [3:0] DATA_OP_CLASS = 4'hE;
  localparam logic [2:0] XFER_CLASS    = 3'h6;
  localparam int DATA_OP_BIT4 = 4;
  localparam int PRE_BIT      = 24;
  localparam int UP_BIT       = 23;
  localparam int LEN_BIT      = 22;
  localparam int WB_BIT       = 21;
  localparam int LOAD_BIT     = 20;
  localparam int CLASS_LSB    = 24;
  localparam int OPC_LSB      = 20;
  localparam int REG_A_LSB    = 16;
  localparam int REG_D_LSB    = 12;
  localparam int NUM_LSB      = 8;
  localparam int INFO_LSB     = 5;
  localparam int REG_B_LSB    = 0;
  localparam int OFFSET_LSB   = 0;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [3:0]  COND_AL   = 4'hE;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {CLS_NONE, CLS_DATA_OP, CLS_XFER} instr_class_e;
endpackage

// ===== verilog/coproc_instr_decode.sv
// coprocessor instruction decoder: classifies, extracts fields, raises undefined trap
// assumes instr_valid pulses one cycle with instr, flags from core, synchronous inputs
// Summary of operation
// RULE1 - act on an instruction only when its condition field passes
// RULE2 - every coprocessor instruction raises the undefined-instruction trap; code traps data operations and transfers only, not bit-4-set 1110 words
// RULE3 - no coprocessor handshake pins and no coprocessor partner exists
// RULE4 - data operations return no result and never stall the core
// RULE5 - a coprocessor may queue data operations and run them in parallel
// RULE6 - data operation: bits 27..24 are 1110 and bit 4 clear
// RULE7 - data operation fields: opcode, operands, destination, number, info
// RULE8 - a coprocessor ignores instructions not carrying its own number
// RULE9 - coprocessor applies opcode to operands and writes destination; the emulator only copies the destination field into result_reg
// RULE10 - data operation costs one sequential cycle plus busy-wait internal cycles
// RULE11 - core supplies addresses; coprocessor supplies data and word count
// RULE12 - transfers have bits 27..25 at 110; base, register, number, offset
// RULE13 - bit 20 chooses load or store, bit 22 chooses transfer length
// RULE14 - word offset added or subtracted, applied before or after transfer
// RULE15 - base written back only when the write-back bit is set
// RULE16 - each further transfer word sits four bytes above the previous
// RULE17 - coprocessor uses the length bit to choose transfer size
module coproc_instr_decode (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr,
  input  wire logic [3:0]  nzcv_flags,
  input  wire logic [31:0] base_value,
  input  wire logic        next_word,
  output logic             undef_trap,
  output logic             coproc_data_operation,
  output logic             coproc_load_transfer,
  output logic             coproc_store_transfer,
  output logic [3:0]       coproc_opcode_field,
  output logic [3:0]       first_operand_reg_field,
  output logic [3:0]       destination_reg_field,
  output logic [3:0]       coproc_number_field,
  output logic [2:0]       coproc_info_field,
  output logic [3:0]       second_operand_reg_field,
  output logic [3:0]       base_register_field,
  output logic             long_transfer,
  output logic [31:0]      xfer_address,
  output logic             base_writeback,
  output logic [31:0]      writeback_value,
  output logic             core_stall
);
  ////////////////////////////////////////////////////////////////////////////
  // condition evaluation
  logic [3:0] cond;
  logic       fn, fz, fc, fv;
  logic       cond_pass;
  assign cond = instr[coproc_decode_pkg::COND_MSB:coproc_decode_pkg::COND_LSB];
  assign {fn, fz, fc, fv} = nzcv_flags;

  always_comb begin
    unique case (cond)
      4'h0: cond_pass = fz;
      4'h1: cond_pass = !fz;
      4'h2: cond_pass = fc;
      4'h3: cond_pass = !fc;
      4'h4: cond_pass = fn;
      4'h5: cond_pass = !fn;
      4'h6: cond_pass = fv;
      4'h7: cond_pass = !fv;
      4'h8: cond_pass = fc && !fz;
      4'h9: cond_pass = !fc || fz;
      4'hA: cond_pass = fn == fv;
      4'hB: cond_pass = fn != fv;
      4'hC: cond_pass = !fz && (fn == fv);
      4'hD: cond_pass = fz || (fn != fv);
      4'hE: cond_pass = 1'b1;
      4'hF: cond_pass = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // field extraction
  wire [3:0] class_bits  = instr[coproc_decode_pkg::CLASS_LSB +: 4];
  wire [3:0] opcode_bits = instr[coproc_decode_pkg::OPC_LSB +: 4];        // [RULE7]
  wire [3:0] reg_a_bits  = instr[coproc_decode_pkg::REG_A_LSB +: 4];
  wire [3:0] reg_d_bits  = instr[coproc_decode_pkg::REG_D_LSB +: 4];
  wire [3:0] num_bits    = instr[coproc_decode_pkg::NUM_LSB +: 4];
  wire [2:0] info_bits   = instr[coproc_decode_pkg::INFO_LSB +: 3];
  wire [3:0] reg_b_bits  = instr[coproc_decode_pkg::REG_B_LSB +: 4];
  wire [7:0] offset_bits = instr[coproc_decode_pkg::OFFSET_LSB +: 8];     // [RULE12]

  ////////////////////////////////////////////////////////////////////////////
  // classification
  wire is_data_op = (class_bits == coproc_decode_pkg::DATA_OP_CLASS)
                    && !instr[coproc_decode_pkg::DATA_OP_BIT4];           // [RULE6]
  wire is_xfer    = class_bits[3:1] == coproc_decode_pkg::XFER_CLASS;     // [RULE12]
  wire is_coproc  = is_data_op || is_xfer;                                // [RULE2]
  wire take       = instr_valid && cond_pass;                             // [RULE1]
  wire is_load    = instr[coproc_decode_pkg::LOAD_BIT];                   // [RULE13]

  ////////////////////////////////////////////////////////////////////////////
  // address arithmetic
  wire [31:0] word_off = {22'h000000, offset_bits, 2'h0};                 // [RULE14]
  wire [31:0] moved    = instr[coproc_decode_pkg::UP_BIT] ? base_value + word_off
                                                          : base_value - word_off;
  wire [31:0] first_addr = instr[coproc_decode_pkg::PRE_BIT] ? moved : base_value;

  // no coprocessor is present: nothing ever answers, so no stall [RULE3] [RULE4]
  assign core_stall = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      undef_trap               <= 1'b0;
      coproc_data_operation    <= 1'b0;
      coproc_load_transfer     <= 1'b0;
      coproc_store_transfer    <= 1'b0;
      coproc_opcode_field      <= 4'h0;
      first_operand_reg_field  <= 4'h0;
      destination_reg_field    <= 4'h0;
      coproc_number_field      <= 4'h0;
      coproc_info_field        <= 3'h0;
      second_operand_reg_field <= 4'h0;
      base_register_field      <= 4'h0;
      long_transfer            <= 1'b0;
      base_writeback           <= 1'b0;
      writeback_value          <= coproc_decode_pkg::RESET_WORD;
      xfer_address             <= coproc_decode_pkg::RESET_WORD;
    end else begin
      undef_trap            <= take && is_coproc;                         // [RULE2]
      coproc_data_operation <= take && is_data_op;                        // [RULE1] [RULE10]
      coproc_load_transfer  <= take && is_xfer && is_load;                // [RULE13]
      coproc_store_transfer <= take && is_xfer && !is_load;               // [RULE13]
      base_writeback        <= take && is_xfer && instr[coproc_decode_pkg::WB_BIT]; // [RULE15]
      if (take && is_coproc) begin
        coproc_opcode_field      <= opcode_bits;                          // [RULE7]
        first_operand_reg_field  <= reg_a_bits;
        destination_reg_field    <= reg_d_bits;
        coproc_number_field      <= num_bits;
        coproc_info_field        <= info_bits;
        second_operand_reg_field <= reg_b_bits;
        base_register_field      <= reg_a_bits;                           // [RULE12]
        long_transfer            <= instr[coproc_decode_pkg::LEN_BIT];    // [RULE13]
        writeback_value          <= moved;                                // [RULE15]
        xfer_address             <= first_addr;                           // [RULE14]
      end else if (next_word) begin
        xfer_address <= xfer_address + coproc_decode_pkg::WORD_STEP;      // [RULE16] [RULE11]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // named steps of a taken instruction, shared by the checks below
  sequence s_data_op_taken;
    take && is_data_op;
  endsequence
  sequence s_xfer_taken;
    take && is_xfer;
  endsequence
  sequence s_two_word_steps;
    (!take && next_word) ##1 (!take && next_word);
  endsequence
  sequence s_idle_after;
    !take;
  endsequence

  chk_trap_on_data_op: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
    instr_valid && cond_pass && is_data_op |=> undef_trap)
    else $error("data operation did not trap");
  chk_xfer_trap: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
    s_xfer_taken |=> undef_trap && !coproc_data_operation)
    else $error("transfer did not trap");
  chk_cond_fail_quiet: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
    !(instr_valid && cond_pass) |=> !undef_trap && !coproc_data_operation)
    else $error("failed condition still acted");
  chk_refused_hold: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
    !(take && is_coproc) |=> $stable(coproc_opcode_field) && $stable(coproc_number_field)
                             && $stable(writeback_value))
    else $error("refused instruction changed fields");
  chk_no_stall: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
    s_data_op_taken |=> coproc_data_operation && !core_stall)
    else $error("core stalled on data operation");
  chk_data_op_pulse: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
    s_data_op_taken ##1 s_idle_after |=> !coproc_data_operation && !undef_trap)
    else $error("data operation held the core");
  chk_bit4_excluded: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
    instr_valid && instr[4] && instr[27:24] == 4'hE |=> !coproc_data_operation)
    else $error("bit 4 set classed as data operation");
  chk_opcode_field: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
    take && is_data_op |=> coproc_opcode_field == $past(instr[23:20])
                          && coproc_info_field == $past(instr[7:5]))
    else $error("data operation fields wrong");
  chk_xfer_fields: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
    s_xfer_taken |=> base_register_field == $past(instr[19:16])
                     && destination_reg_field == $past(instr[15:12])
                     && coproc_number_field == $past(instr[11:8]))
    else $error("transfer fields wrong");
  chk_xfer_dir: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
    take && is_xfer |=> coproc_load_transfer == $past(instr[20])
                       && coproc_store_transfer != $past(instr[20]))
    else $error("transfer direction wrong");
  chk_long_bit: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
    s_xfer_taken |=> long_transfer == $past(instr[22]))
    else $error("transfer length bit wrong");
  chk_offset_calc: assert property (@(posedge clk) disable iff (sys_rst) // [RULE14]
    take && is_xfer && instr[24] && instr[23] |=>
      xfer_address == $past(base_value) + {22'h000000, $past(instr[7:0]), 2'h0})
    else $error("pre-indexed up address wrong");
  chk_down_offset: assert property (@(posedge clk) disable iff (sys_rst) // [RULE14]
    take && is_xfer && !instr[23] |=>
      writeback_value == $past(base_value) - {22'h000000, $past(instr[7:0]), 2'h0})
    else $error("down offset not subtracted");
  chk_post_index: assert property (@(posedge clk) disable iff (sys_rst) // [RULE14]
    take && is_xfer && !instr[24] |=> xfer_address == $past(base_value))
    else $error("post-indexed address not base");
  chk_writeback_bit: assert property (@(posedge clk) disable iff (sys_rst) // [RULE15]
    take && is_xfer && !instr[21] |=> !base_writeback)
    else $error("write-back without bit");
  chk_word_step: assert property (@(posedge clk) disable iff (sys_rst) // [RULE16]
    !take && next_word |=> xfer_address == $past(xfer_address) + 32'h0000_0004)
    else $error("next word not four bytes up");
  chk_two_word_walk: assert property (@(posedge clk) disable iff (sys_rst) // [RULE16]
    s_xfer_taken ##1 s_two_word_steps |=>
      xfer_address == $past(xfer_address, 2) + 32'h0000_0008)
    else $error("second step not eight bytes up");
  chk_step_blocked: assert property (@(posedge clk) disable iff (sys_rst) // [RULE16]
    take && is_xfer && !instr[24] && next_word |=> xfer_address == $past(base_value))
    else $error("step taken with a new transfer");
endmodule

// ===== verif/coproc_emulator.sv
// emulated coprocessor: counts the undefined traps that it would service
// assumes trap pulse and number field come registered from the decoder
module coproc_emulator #(
  parameter logic [3:0] OWN_NUM    = 4'h2,
  parameter logic [7:0] LONG_WORDS = 8'h10
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       undef_trap,
  input  wire logic       coproc_data_operation,
  input  wire logic       long_transfer,
  input  wire logic [3:0] coproc_number_field,
  input  wire logic [3:0] destination_reg_field,
  output logic      [7:0] handled,
  output logic      [3:0] result_reg,
  output logic      [7:0] words_due
);
  timeunit 1ns;
  timeprecision 1ps;
  wire mine = undef_trap && coproc_number_field == OWN_NUM;
  // queued work never stalls the core
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      handled    <= 8'h00;
      result_reg <= 4'h0;
      words_due  <= 8'h00;
    end else if (mine) begin
      handled <= handled + 8'h01;
      if (coproc_data_operation) result_reg <= destination_reg_field;
      else words_due <= long_transfer ? LONG_WORDS : 8'h01;
    end
  end
endmodule

// ===== verif/coproc_instr_decode_tb_top.sv
// self-checking bench for the coprocessor instruction decoder
// assumes one-cycle output latency and the emulator as far side
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t mismatch at line %0d", $time, `__LINE__); end end
module coproc_instr_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, instr_valid = 0, next_word = 0;
  logic [31:0] instr = 32'h0, base_value = 32'h0;
  logic [3:0]  nzcv_flags = 4'h0;
  logic undef_trap, coproc_data_operation, coproc_load_transfer, coproc_store_transfer;
  logic [3:0] coproc_opcode_field, first_operand_reg_field, destination_reg_field;
  logic [3:0] coproc_number_field, second_operand_reg_field, base_register_field;
  logic [2:0] coproc_info_field;
  logic long_transfer, base_writeback, core_stall;
  logic [31:0] xfer_address, writeback_value;
  logic [7:0] handled;
  logic [3:0] result_reg;
  logic [7:0] words_due;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  coproc_instr_decode dut (.clk, .sys_rst, .instr_valid, .instr, .nzcv_flags, .base_value,
    .next_word, .undef_trap, .coproc_data_operation, .coproc_load_transfer,
    .coproc_store_transfer, .coproc_opcode_field, .first_operand_reg_field,
    .destination_reg_field, .coproc_number_field, .coproc_info_field,
    .second_operand_reg_field, .base_register_field, .long_transfer, .xfer_address,
    .base_writeback, .writeback_value, .core_stall);
  coproc_emulator #(.OWN_NUM(4'h2), .LONG_WORDS(8'h10)) emu (.clk, .sys_rst, .undef_trap,
    .coproc_data_operation, .long_transfer, .coproc_number_field, .destination_reg_field,
    .handled, .result_reg, .words_due);
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic issue(input logic [31:0] w, input logic [31:0] b);
    @(posedge clk) #1 instr_valid = 1;
    instr = w;
    base_value = b;
    @(posedge clk) #1 instr_valid = 0;
  endtask
  task automatic data_op_fields();
    issue(32'hEEA21143, 32'h0);
    `CHK({undef_trap, coproc_data_operation, core_stall}, 3'b110)
    `CHK({coproc_opcode_field, first_operand_reg_field, destination_reg_field}, 12'hA21)
    `CHK({coproc_number_field, coproc_info_field, second_operand_reg_field}, 11'h0A3)
    @(posedge clk) #1 `CHK({undef_trap, coproc_data_operation}, 2'b00)
    issue(32'hEEA21153, 32'h0);
    `CHK(undef_trap, 1'b0)
    `CHK({coproc_opcode_field, second_operand_reg_field}, 8'hA3)
    issue(32'h0E5C3240, 32'h0);
    `CHK({undef_trap, coproc_data_operation, coproc_number_field}, 6'h01)
    issue(32'hE1A00000, 32'h0);
    `CHK(undef_trap, 1'b0)
  endtask
  task automatic cond_table(input logic [3:0] f, input logic [15:0] pass);
    nzcv_flags = f;
    for (int i = 0; i < 16; i++) begin
      issue({i[3:0], 28'hE012103}, 32'h0);
      `CHK(undef_trap, pass[i])
    end
  endtask
  task automatic store_pre_up();
    nzcv_flags = 4'h0;
    issue(32'hEDA53206, 32'h0000_1000);
    `CHK({undef_trap, coproc_store_transfer, coproc_load_transfer, long_transfer}, 4'hC)
    `CHK({base_register_field, destination_reg_field, coproc_number_field}, 12'h532)
    `CHK({base_writeback, xfer_address, writeback_value}, {1'b1, 64'h1018_0000_1018})
    next_word = 1;
    @(posedge clk) #1 `CHK(xfer_address, 32'h0000_101C)
    @(posedge clk) #1 next_word = 0;
    `CHK(xfer_address, 32'h0000_1020)
  endtask
  task automatic load_post_down();
    @(posedge clk) #1 next_word = 1;
    issue(32'hEC5749FF, 32'h0000_2000);
    next_word = 0;
    `CHK({undef_trap, coproc_load_transfer, coproc_store_transfer, long_transfer}, 4'hD)
    `CHK({base_writeback, xfer_address, writeback_value}, {1'b0, 64'h2000_0000_1C04})
    `CHK({base_register_field, coproc_number_field}, 8'h79)
  endtask
  task automatic emulator_service();
    issue(32'hEE5C3240, 32'h0);
    @(posedge clk) #1 `CHK({handled, result_reg}, 12'h023)
    issue(32'hEC5042FF, 32'h0000_3000);
    @(posedge clk) #1 `CHK({handled, words_due}, 16'h0310)
  endtask
  task automatic mid_reset();
    issue(32'hEDA53206, 32'h0000_1000);
    sys_rst = 1;
    @(posedge clk);
    #1 `CHK({undef_trap, base_register_field, xfer_address, handled}, 45'h0)
    sys_rst = 0;
    issue(32'hEE012103, 32'h0);
    `CHK({undef_trap, coproc_data_operation, handled}, 10'h300)
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 sys_rst = 0;
    `CHK({undef_trap, xfer_address}, 33'h0)
    data_op_fields();
    cond_table(4'h0, 16'h56AA);
    cond_table(4'hF, 16'h6655);
    store_pre_up();
    load_post_down();
    `CHK({handled, words_due}, 16'h0101)
    emulator_service();
    mid_reset();
    conclude();
  end
endmodule
